/* File: design/pbmc_pkg.sv */
/*
 * Constants shared by the basic mode-control block: management register
 * addresses, bit positions, reset values and timing counts.
 * Assumes a 250 MHz core clock feeding every user of these figures.
 */
package pbmc_pkg;
   // management register addresses
   localparam logic [4:0]  REG_CTRL          = 5'h00;
   localparam logic [4:0]  REG_STAT          = 5'h01;
   localparam logic [4:0]  REG_DETAIL        = 5'h11;

   // control register bit positions
   localparam int          BIT_RESET         = 15;
   localparam int          BIT_LOOP          = 14;
   localparam int          BIT_RATE          = 13;
   localparam int          BIT_NEG_EN        = 12;
   localparam int          BIT_LOW_POWER     = 11;
   localparam int          BIT_ISOLATE       = 10;
   localparam int          BIT_RESTART       = 9;
   localparam int          BIT_DUPLEX        = 8;
   localparam int          BIT_COL_TEST      = 7;

   // status and detailed status bit positions
   localparam int          BIT_NEG_DONE      = 5;
   localparam int          BIT_LINK          = 2;
   localparam int          BIT_DET_RATE      = 15;
   localparam int          BIT_DET_DUPLEX    = 14;

   // reset values
   localparam logic        RST_LOOP          = 1'b0;
   localparam logic        RST_RATE          = 1'b1;
   localparam logic        RST_NEG_EN        = 1'b1;
   localparam logic        RST_LOW_POWER     = 1'b0;
   localparam logic        RST_RESTART       = 1'b0;
   localparam logic        RST_DUPLEX        = 1'b0;
   localparam logic        RST_COL_TEST      = 1'b0;
   localparam logic        RST_NEG_DONE      = 1'b0;
   localparam logic        RST_LINK          = 1'b0;
   localparam logic [4:0]  ISO_ADDR          = 5'h00;

   // timing
   localparam int          CLK_NS            = 4;
   localparam int          SOFT_RESET_NS     = 1000;
   localparam int          SOFT_RESET_CYCLES = (SOFT_RESET_NS + CLK_NS - 1) / CLK_NS;
endpackage

/* File: design/pbmc_soft_reset.sv */
/*
 * Software reset timer: holds busy high for a fixed number of cycles
 * after a start pulse.
 * Assumes start is a one-cycle pulse synchronous to i_clk.
 */
`timescale 1ns/1ns
`default_nettype none
module pbmc_soft_reset #(
   parameter int CYCLES = pbmc_pkg::SOFT_RESET_CYCLES
) (
   input  wire logic i_clk,
   input  wire logic i_reset_n,
   input  wire logic i_start,
   output var  logic o_busy
);
   localparam int CW = $clog2(CYCLES + 1);

   logic [CW-1:0] count;
   wire           last = (count == CW'(1));

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         count  <= '0;
         o_busy <= 1'b0;
      end else if (i_start) begin
         count  <= CW'(CYCLES);
         o_busy <= 1'b1;
      end else if (o_busy) begin
         count  <= count - CW'(1);
         o_busy <= !last;
      end
   end
endmodule
`default_nettype wire

/* File: design/pbmc_col_test.sv */
/*
 * Collision path: during the test COL follows the transmit enable,
 * otherwise it carries the line collision unless loopback masks it.
 * Assumes all inputs are synchronous to i_clk.
 */
`timescale 1ns/1ns
`default_nettype none
module pbmc_col_test (
   input  wire logic i_clk,
   input  wire logic i_reset_n,
   input  wire logic i_test_en,
   input  wire logic i_loop_en,
   input  wire logic i_tx_en,
   input  wire logic i_line_col,
   output var  logic o_col
);
   // loopback turns off real collision detection; the test overrides that
   wire next_col = i_test_en ? i_tx_en : (i_line_col && !i_loop_en);

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_col <= 1'b0;
      end else begin
         o_col <= next_col;
      end
   end
endmodule
`default_nettype wire

/* File: design/pbmc_basic_mode_control.sv */
/*
 * Basic mode-control register of the PHY, its mode resolution (strap or
 * register, negotiated or forced), low-power, isolate, loopback and
 * collision-test gating of the MAC-side data path.
 * Assumes a parallel management port decoded from the serial management
 * frame outside, and a negotiation engine that answers restart requests.
 */
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - hardware mode: rate comes from the rate strap, register bit ignored
// - hardware mode: detailed status shows the active link rate
// - software mode, negotiation on: rate follows the negotiation result
// - software mode, negotiation off: rate bit 0 gives 10, 1 gives 100 Mbps
// - hardware mode: negotiation enable follows the negotiation strap
// - software mode: negotiation bit picks negotiated or forced rate and duplex
// - low power: internals off, MAC outputs low, pair transmitter tri-stated
// - entering low power resets only the latching status bits
// - any reset returns every management bit to its default
// - isolate: MAC outputs high impedance, MAC inputs ignored
// - isolate defaults to 1 at PHY address zero, else 0
// - restart write ignored while negotiation is disabled
// - restart bit starts negotiation and self-clears once it begins
// - hardware mode: duplex comes from the duplex strap
// - hardware mode: detailed status shows the active link duplex
// - software mode, negotiation on: duplex follows negotiation result
// - software mode, negotiation off: duplex bit 0 half, 1 full
// - loopback makes the duplex bit irrelevant
// - collision test off: COL does not follow transmit enable
// - collision test on, even in loopback: COL tracks transmit enable quickly
// - reserved low control bits read as zero
// - reset bit starts a timed software reset, reads 1 until done
// - loopback returns MAC transmit data to MAC receive
module pbmc_basic_mode_control (
   input  wire logic        i_clk,
   input  wire logic        i_reset_n,
   input  wire logic        i_hard_soft_select_pin,
   input  wire logic        i_rate_strap_pin,
   input  wire logic        i_negotiation_strap_pin,
   input  wire logic        i_duplex_strap_pin,
   input  wire logic [4:0]  i_phy_addr,
   input  wire logic        i_mgmt_wr,
   input  wire logic        i_mgmt_rd,
   input  wire logic [4:0]  i_mgmt_addr,
   input  wire logic [15:0] i_mgmt_wdata,
   output var  logic [15:0] o_mgmt_rdata,
   output var  logic        o_mgmt_rvalid,
   input  wire logic        i_neg_started,
   input  wire logic        i_neg_done,
   input  wire logic        i_neg_rate_100,
   input  wire logic        i_neg_full_duplex,
   input  wire logic        i_link_up,
   output var  logic        o_neg_enable,
   output var  logic        o_neg_restart,
   output var  logic        o_link_rate_100,
   output var  logic        o_link_full_duplex,
   output var  logic        o_power_down,
   output var  logic        o_soft_reset_busy,
   output var  logic        o_pair_transmit_tristate,
   input  wire logic [3:0]  i_txd,
   input  wire logic        i_tx_en,
   input  wire logic        i_tx_er,
   input  wire logic [3:0]  i_line_rxd,
   input  wire logic        i_line_rx_dv,
   input  wire logic        i_line_rx_er,
   input  wire logic        i_line_crs,
   input  wire logic        i_line_col,
   output var  logic [3:0]  o_rxd,
   output var  logic        o_rx_dv,
   output var  logic        o_rx_er,
   output var  logic        o_crs,
   output var  logic        o_col,
   output var  logic        o_mac_oe,
   output var  logic [3:0]  o_line_txd,
   output var  logic        o_line_tx_en,
   output var  logic        o_line_tx_er
);
   logic init_pend;
   logic loop_bit;
   logic rate_bit;
   logic neg_bit;
   logic low_bit;
   logic iso_bit;
   logic restart_bit;
   logic duplex_bit;
   logic col_bit;
   logic low_q;
   logic neg_done_lh;
   logic link_ll;
   logic sreset_busy;
   logic col_raw;

   // accesses are shut out while the software reset runs, except reads
   wire       sw_mode      = i_hard_soft_select_pin;
   wire       wr_ctrl      = i_mgmt_wr && (i_mgmt_addr == pbmc_pkg::REG_CTRL) && !sreset_busy;
   wire       rd_stat      = i_mgmt_rd && (i_mgmt_addr == pbmc_pkg::REG_STAT) && !sreset_busy;
   wire       sreset_start = wr_ctrl && i_mgmt_wdata[pbmc_pkg::BIT_RESET];
   wire       load_dflt    = init_pend || sreset_start;
   wire       iso_dflt     = (i_phy_addr == pbmc_pkg::ISO_ADDR);
   wire       next_neg_on  = sw_mode ? i_mgmt_wdata[pbmc_pkg::BIT_NEG_EN]
                                     : i_negotiation_strap_pin;
   wire       restart_req  = wr_ctrl && !sreset_start && next_neg_on
                             && i_mgmt_wdata[pbmc_pkg::BIT_RESTART];
   wire       low_entry    = low_bit && !low_q;
   wire       path_on      = !low_bit && !iso_bit;

   // mode resolution
   wire       eff_neg      = sw_mode ? neg_bit : i_negotiation_strap_pin;
   wire       eff_rate     = !sw_mode ? i_rate_strap_pin
                             : (neg_bit ? i_neg_rate_100 : rate_bit);
   wire       eff_duplex   = !sw_mode ? i_duplex_strap_pin
                             : neg_bit ? i_neg_full_duplex
                             : loop_bit ? 1'b1 : duplex_bit;

   wire [15:0] ctrl_word   = {sreset_busy, loop_bit, rate_bit, neg_bit, low_bit,
                              iso_bit, restart_bit, duplex_bit, col_bit, 7'h00};
   wire [15:0] stat_word   = 16'(neg_done_lh) << pbmc_pkg::BIT_NEG_DONE
                             | 16'(link_ll) << pbmc_pkg::BIT_LINK;
   wire [15:0] det_word    = 16'(eff_rate) << pbmc_pkg::BIT_DET_RATE
                             | 16'(eff_duplex) << pbmc_pkg::BIT_DET_DUPLEX;
   wire [15:0] rd_sel      = (i_mgmt_addr == pbmc_pkg::REG_CTRL)   ? ctrl_word
                           : (i_mgmt_addr == pbmc_pkg::REG_STAT)   ? stat_word
                           : (i_mgmt_addr == pbmc_pkg::REG_DETAIL) ? det_word
                           : 16'h0000;

   // mac-facing data: loopback takes transmit data, else the line
   wire [3:0] next_rxd     = path_on ? (loop_bit ? i_txd : i_line_rxd) : 4'h0;
   wire       next_rx_dv   = path_on && (loop_bit ? i_tx_en : i_line_rx_dv);
   wire       next_rx_er   = path_on && (loop_bit ? i_tx_er : i_line_rx_er);
   wire       next_crs     = path_on && (loop_bit ? i_tx_en : i_line_crs);
   wire       tx_pass      = path_on && !loop_bit;

   pbmc_soft_reset u_soft_reset (
      .i_clk     (i_clk),
      .i_reset_n (i_reset_n),
      .i_start   (sreset_start),
      .o_busy    (sreset_busy)
   );

   pbmc_col_test u_col_test (
      .i_clk      (i_clk),
      .i_reset_n  (i_reset_n),
      .i_test_en  (col_bit),
      .i_loop_en  (loop_bit),
      .i_tx_en    (i_tx_en),
      .i_line_col (i_line_col),
      .o_col      (col_raw)
   );

   // control register; isolate default needs the address, so it loads
   // on the first edge after release instead of inside the async reset
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         init_pend  <= 1'b1;
         loop_bit   <= pbmc_pkg::RST_LOOP;
         rate_bit   <= pbmc_pkg::RST_RATE;
         neg_bit    <= pbmc_pkg::RST_NEG_EN;
         low_bit    <= pbmc_pkg::RST_LOW_POWER;
         iso_bit    <= 1'b1;
         duplex_bit <= pbmc_pkg::RST_DUPLEX;
         col_bit    <= pbmc_pkg::RST_COL_TEST;
      end else if (load_dflt) begin
         init_pend  <= 1'b0;
         loop_bit   <= pbmc_pkg::RST_LOOP;
         rate_bit   <= pbmc_pkg::RST_RATE;
         neg_bit    <= pbmc_pkg::RST_NEG_EN;
         low_bit    <= pbmc_pkg::RST_LOW_POWER;
         iso_bit    <= iso_dflt;
         duplex_bit <= pbmc_pkg::RST_DUPLEX;
         col_bit    <= pbmc_pkg::RST_COL_TEST;
      end else if (wr_ctrl) begin
         loop_bit   <= i_mgmt_wdata[pbmc_pkg::BIT_LOOP];
         rate_bit   <= i_mgmt_wdata[pbmc_pkg::BIT_RATE];
         neg_bit    <= i_mgmt_wdata[pbmc_pkg::BIT_NEG_EN];
         low_bit    <= i_mgmt_wdata[pbmc_pkg::BIT_LOW_POWER];
         iso_bit    <= i_mgmt_wdata[pbmc_pkg::BIT_ISOLATE];
         duplex_bit <= i_mgmt_wdata[pbmc_pkg::BIT_DUPLEX];
         col_bit    <= i_mgmt_wdata[pbmc_pkg::BIT_COL_TEST];
      end
   end

   // restart: a new request in the start cycle wins over the clear
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         restart_bit <= pbmc_pkg::RST_RESTART;
      end else if (load_dflt) begin
         restart_bit <= pbmc_pkg::RST_RESTART;
      end else if (restart_req) begin
         restart_bit <= 1'b1;
      end else if (i_neg_started) begin
         restart_bit <= 1'b0;
      end
   end

   // latching status; the event wins over the read that would clear it
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         low_q       <= 1'b0;
         neg_done_lh <= pbmc_pkg::RST_NEG_DONE;
         link_ll     <= pbmc_pkg::RST_LINK;
      end else begin
         low_q <= low_bit;
         if (load_dflt || low_entry) begin
            neg_done_lh <= pbmc_pkg::RST_NEG_DONE;
            link_ll     <= pbmc_pkg::RST_LINK;
         end else begin
            if (i_neg_done && !low_bit) begin // engine output is stale once powered down
               neg_done_lh <= 1'b1;
            end else if (rd_stat) begin
               neg_done_lh <= 1'b0;
            end
            if (!i_link_up) begin
               link_ll <= 1'b0;
            end else if (rd_stat) begin
               link_ll <= 1'b1;
            end
         end
      end
   end

   // read port; reads stay open during software reset to show the busy bit
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_mgmt_rdata  <= 16'h0000;
         o_mgmt_rvalid <= 1'b0;
      end else begin
         o_mgmt_rvalid <= i_mgmt_rd;
         if (i_mgmt_rd) begin
            o_mgmt_rdata <= rd_sel;
         end
      end
   end

   // mode outputs
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_neg_enable             <= 1'b0;
         o_neg_restart            <= 1'b0;
         o_link_rate_100          <= 1'b0;
         o_link_full_duplex       <= 1'b0;
         o_power_down             <= 1'b0;
         o_soft_reset_busy        <= 1'b0;
         o_pair_transmit_tristate <= 1'b0;
      end else begin
         o_neg_enable             <= eff_neg && !low_bit;
         o_neg_restart            <= restart_bit;
         o_link_rate_100          <= eff_rate;
         o_link_full_duplex       <= eff_duplex;
         o_power_down             <= low_bit;
         o_soft_reset_busy        <= sreset_busy;
         o_pair_transmit_tristate <= low_bit;
      end
   end

   // mac and line data path
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_rxd        <= 4'h0;
         o_rx_dv      <= 1'b0;
         o_rx_er      <= 1'b0;
         o_crs        <= 1'b0;
         o_col        <= 1'b0;
         o_mac_oe     <= 1'b0;
         o_line_txd   <= 4'h0;
         o_line_tx_en <= 1'b0;
         o_line_tx_er <= 1'b0;
      end else begin
         o_rxd        <= next_rxd;
         o_rx_dv      <= next_rx_dv;
         o_rx_er      <= next_rx_er;
         o_crs        <= next_crs;
         o_col        <= path_on && col_raw;
         o_mac_oe     <= !iso_bit;
         o_line_txd   <= tx_pass ? i_txd : 4'h0;
         o_line_tx_en <= tx_pass && i_tx_en;
         o_line_tx_er <= tx_pass && i_tx_er;
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);

   a_hw_rate_strap: assert property (
      !sw_mode |=> o_link_rate_100 == $past(i_rate_strap_pin))
      else $error("rate does not follow strap in hardware mode");
   a_det_rate_read: assert property (
      (i_mgmt_rd && i_mgmt_addr == pbmc_pkg::REG_DETAIL && !sw_mode)
      |=> o_mgmt_rdata[pbmc_pkg::BIT_DET_RATE] == $past(i_rate_strap_pin) && o_mgmt_rvalid)
      else $error("detailed status rate wrong");
   a_neg_rate_use: assert property (
      (sw_mode && neg_bit) |=> o_link_rate_100 == $past(i_neg_rate_100))
      else $error("negotiated rate not used");
   a_forced_rate: assert property (
      (sw_mode && !neg_bit) |=> o_link_rate_100 == $past(rate_bit))
      else $error("forced rate not applied");
   a_hw_neg_strap: assert property (
      (!sw_mode && !low_bit) |=> o_neg_enable == $past(i_negotiation_strap_pin))
      else $error("negotiation enable ignores strap");
   a_low_power_out: assert property (
      (low_bit && !wr_ctrl) ##1 low_bit |-> o_rxd == 4'h0 && !o_rx_dv
      && o_pair_transmit_tristate && o_power_down)
      else $error("low power outputs wrong");
   a_iso_hold_off: assert property (
      iso_bit |=> !o_mac_oe && !o_line_tx_en && !o_rx_dv)
      else $error("isolate not applied");
   a_restart_block: assert property (
      (wr_ctrl && !sreset_start && sw_mode && !i_mgmt_wdata[pbmc_pkg::BIT_NEG_EN]
       && i_mgmt_wdata[pbmc_pkg::BIT_RESTART] && !restart_bit) |=> !restart_bit)
      else $error("restart accepted while negotiation off");
   a_forced_duplex: assert property (
      (sw_mode && !neg_bit && !loop_bit)
      |=> o_link_full_duplex == $past(duplex_bit))
      else $error("forced duplex not applied");
   a_col_tracks_tx: assert property (
      (col_bit && path_on && i_tx_en) ##1 (col_bit && path_on) |=> o_col)
      else $error("collision test did not raise col");
   a_col_idle_loop: assert property (
      (!col_bit && loop_bit && path_on) ##1 (!col_bit && loop_bit) |=> !o_col)
      else $error("col follows transmit without test");
   a_soft_reset_hold: assert property (
      sreset_start |=> sreset_busy [*8] ##0 (neg_bit && !restart_bit))
      else $error("software reset not held or defaults missing");
   a_hw_duplex_strap: assert property (
      !sw_mode |=> o_link_full_duplex == $past(i_duplex_strap_pin))
      else $error("duplex does not follow strap in hardware mode");
   a_det_duplex_read: assert property (
      (i_mgmt_rd && i_mgmt_addr == pbmc_pkg::REG_DETAIL && !sw_mode)
      |=> o_mgmt_rdata[pbmc_pkg::BIT_DET_DUPLEX] == $past(i_duplex_strap_pin))
      else $error("detailed status duplex wrong");
   a_reserved_zero: assert property (
      (i_mgmt_rd && i_mgmt_addr == pbmc_pkg::REG_CTRL) |=> o_mgmt_rdata[6:0] == 7'h00)
      else $error("reserved control bits not zero");
   a_restart_self_clr: assert property (
      (restart_bit && i_neg_started && !restart_req && !load_dflt) |=> !restart_bit)
      else $error("restart bit not cleared after start");
   a_latch_low_entry: assert property (
      low_entry |=> !neg_done_lh && !link_ll)
      else $error("latching status not reset on low power");
endmodule
`default_nettype wire

/* File: sim/pbmc_neg_model.sv */
/*
 * Negotiation engine stand-in: a rising restart request starts a prompt
 * or slow count, then started pulses once and done stays high.
 * Assumes restart is a level held by the design until started is seen.
 */
`timescale 1ns/1ns
`default_nettype none
module pbmc_neg_model (
   input  wire logic i_clk,
   input  wire logic i_reset_n,
   input  wire logic i_enable,
   input  wire logic i_restart,
   input  wire logic i_slow,
   output var  logic o_started,
   output var  logic o_done
);
   logic [4:0] cnt;
   logic       restart_q;
   wire  [4:0] lim = i_slow ? 5'h14 : 5'h02;
   // edge trigger, so a restart level still high after started is not taken twice
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         cnt       <= 5'h00;
         restart_q <= 1'b0;
         o_started <= 1'b0;
         o_done    <= 1'b0;
      end else begin
         restart_q <= i_restart;
         o_started <= 1'b0;
         if (!i_enable) begin
            o_done <= 1'b0;
            cnt    <= 5'h00;
         end else if (i_restart && !restart_q) begin
            o_done <= 1'b0;
            cnt    <= 5'h01;
         end else if (cnt == lim) begin
            o_started <= 1'b1;
            cnt       <= 5'h00;
         end else if (cnt != 5'h00) begin
            cnt <= cnt + 5'h01;
         end
         if (o_started) begin
            o_done <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

/* File: sim/testbench.sv */
/*
 * Self-checking bench: register model, mode resolution, low power,
 * isolate, loopback, collision test and software reset.
 * Assumes the design package, design modules and partner model compile first.
 */
`timescale 1ns/1ns
`default_nettype none
module testbench;
   logic        clk = 1'b0, rst_n = 1'b0, hs = 1'b1, s_rate = 1'b0, s_neg = 1'b0;
   logic        s_dup = 1'b0, wr = 1'b0, rd = 1'b0, tx_en = 1'b0, link = 1'b0;
   logic        n_r100 = 1'b0, n_fd = 1'b0, slow = 1'b1, tx_er = 1'b0, lcol = 1'b0;
   logic [4:0]  paddr = 5'h01, addr = 5'h00;
   logic [15:0] wdata = 16'h0000;
   logic [3:0]  txd = 4'h0, lrxd = 4'h0, exp_nib;
   wire logic [15:0] rdata;
   wire logic [3:0]  rxd, ltxd;
   wire logic        rvalid, n_start, n_done, neg_en, restart, rate, fdx, pdn, busy, tri_s;
   wire logic        rx_dv, rx_er, crs, col, mac_oe, ltx_en, ltx_er;
   int          err_total = 0, n_checks = 0, seed = 32'h31676295, exp_ctrl, n;
   logic [3:0]  q_nib[$];
   always #2 clk = ~clk;
   pbmc_basic_mode_control i_dut (.i_clk(clk), .i_reset_n(rst_n),
      .i_hard_soft_select_pin(hs), .i_rate_strap_pin(s_rate), .i_negotiation_strap_pin(s_neg),
      .i_duplex_strap_pin(s_dup), .i_phy_addr(paddr), .i_mgmt_wr(wr), .i_mgmt_rd(rd),
      .i_mgmt_addr(addr), .i_mgmt_wdata(wdata), .o_mgmt_rdata(rdata), .o_mgmt_rvalid(rvalid),
      .i_neg_started(n_start), .i_neg_done(n_done), .i_neg_rate_100(n_r100),
      .i_neg_full_duplex(n_fd), .i_link_up(link), .o_neg_enable(neg_en),
      .o_neg_restart(restart), .o_link_rate_100(rate), .o_link_full_duplex(fdx),
      .o_power_down(pdn), .o_soft_reset_busy(busy), .o_pair_transmit_tristate(tri_s),
      .i_txd(txd), .i_tx_en(tx_en), .i_tx_er(tx_er), .i_line_rxd(lrxd), .i_line_rx_dv(1'b0),
      .i_line_rx_er(1'b0), .i_line_crs(1'b0), .i_line_col(lcol), .o_rxd(rxd),
      .o_rx_dv(rx_dv), .o_rx_er(rx_er), .o_crs(crs), .o_col(col), .o_mac_oe(mac_oe),
      .o_line_txd(ltxd), .o_line_tx_en(ltx_en), .o_line_tx_er(ltx_er));
   pbmc_neg_model i_neg (.i_clk(clk), .i_reset_n(rst_n), .i_enable(neg_en),
      .i_restart(restart), .i_slow(slow), .o_started(n_start), .o_done(n_done));
   task automatic complete_run;
      if (err_total == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      chk_reg({15'h0000, got}, {15'h0000, exp});
   endtask
   task automatic cyc(input int k);
      repeat (k) @(negedge clk);
   endtask
   task automatic mwr(input logic [4:0] a, input logic [15:0] d);
      @(negedge clk);
      addr = a;
      wdata = d & 16'hFF80;
      wr = 1'b1;
      @(negedge clk);
      wr = 1'b0;
   endtask
   task automatic mrd(input logic [4:0] a, input logic [15:0] exp);
      int k;
      @(negedge clk);
      addr = a;
      rd = 1'b1;
      @(negedge clk);
      rd = 1'b0;
      k = 0;
      while (rvalid !== 1'b1 && k < 4) begin
         @(negedge clk);
         k++;
      end
      if (k == 4) begin
         err_total++;
         complete_run();
      end
      chk_reg(rdata, exp);
   endtask
   task automatic wait_col(input logic v, input int lim);
      int k;
      k = 0;
      while (col !== v && k < lim) begin
         @(negedge clk);
         k++;
      end
      chk_bit(col, v);
      if (col !== v) begin
         complete_run();
      end
   endtask
   initial begin
      cyc(10);
      rst_n = 1'b1;
      cyc(2);
      mrd(pbmc_pkg::REG_CTRL, 16'h3000);
      chk_bit(mac_oe, 1'b1);
      for (int i = 0; i < 4; i++) begin
         exp_ctrl = (i[1] << pbmc_pkg::BIT_RATE) | (i[0] << pbmc_pkg::BIT_DUPLEX);
         mwr(pbmc_pkg::REG_CTRL, exp_ctrl[15:0]);
         cyc(2);
         chk_bit(rate, i[1]);
         chk_bit(fdx, i[0]);
         chk_bit(neg_en, 1'b0);
         mrd(pbmc_pkg::REG_CTRL, exp_ctrl[15:0]);
      end
      mwr(pbmc_pkg::REG_CTRL, 16'h0200);
      cyc(2);
      chk_bit(restart, 1'b0);
      mrd(pbmc_pkg::REG_CTRL, 16'h0000);
      n_r100 = 1'($random(seed));
      n_fd = ~n_r100;
      link = 1'b1;
      mwr(pbmc_pkg::REG_CTRL, 16'h1200);
      cyc(2);
      chk_bit(restart, 1'b1);
      n = 0;
      while (restart !== 1'b0 && n < 60) begin
         @(negedge clk);
         n++;
      end
      if (n == 60) begin
         err_total++;
         complete_run();
      end
      cyc(4);
      chk_bit(rate, n_r100);
      chk_bit(fdx, n_fd);
      mrd(pbmc_pkg::REG_CTRL, 16'h1000);
      mrd(pbmc_pkg::REG_STAT, 16'h0020);
      mrd(pbmc_pkg::REG_STAT, 16'h0024);
      link = 1'b0;
      tx_en = 1'b1;
      lrxd = 4'($random(seed)) | 4'h1;
      mwr(pbmc_pkg::REG_CTRL, 16'h1800);
      cyc(3);
      mrd(pbmc_pkg::REG_STAT, 16'h0000);
      mrd(pbmc_pkg::REG_CTRL, 16'h1800);
      chk_bit(pdn, 1'b1);
      chk_bit(tri_s, 1'b1);
      chk_reg({12'h000, rxd}, 16'h0000);
      chk_bit(ltx_en, 1'b0);
      chk_bit(neg_en, 1'b0);
      mwr(pbmc_pkg::REG_CTRL, 16'h0400);
      cyc(3);
      chk_bit(mac_oe, 1'b0);
      chk_bit(ltx_en, 1'b0);
      mrd(pbmc_pkg::REG_CTRL, 16'h0400);
      txd = 4'($random(seed));
      tx_er = 1'b1;
      lcol = 1'b1;
      mwr(pbmc_pkg::REG_CTRL, 16'h0000);
      cyc(2);
      chk_reg({12'h000, ltxd}, {12'h000, txd});
      chk_bit(ltx_er, 1'b1);
      chk_reg({12'h000, rxd}, {12'h000, lrxd});
      chk_bit(col, 1'b1);
      mwr(pbmc_pkg::REG_CTRL, 16'h4000);
      cyc(2);
      chk_bit(fdx, 1'b1);
      for (int i = 0; i < 16; i++) begin
         txd = 4'($random(seed));
         tx_er = txd[0];
         q_nib.push_back(txd);
         @(negedge clk);
         exp_nib = q_nib.pop_front();
         chk_reg({12'h000, rxd}, {12'h000, exp_nib});
         chk_bit(rx_er, exp_nib[0]);
         chk_bit(rx_dv, 1'b1);
         chk_bit(crs, 1'b1);
         chk_bit(ltx_en, 1'b0);
         chk_bit(col, 1'b0);
      end
      mwr(pbmc_pkg::REG_CTRL, 16'h4080);
      wait_col(1'b1, 1280);
      tx_en = 1'b0;
      wait_col(1'b0, 10);
      mwr(pbmc_pkg::REG_CTRL, 16'h0000);
      link = 1'b1;
      hs = 1'b0;
      for (int i = 0; i < 4; i++) begin
         {s_rate, s_dup} = i[1:0];
         exp_ctrl = 32'h1000 | (!i[1] << pbmc_pkg::BIT_RATE) | (!i[0] << pbmc_pkg::BIT_DUPLEX);
         mwr(pbmc_pkg::REG_CTRL, exp_ctrl[15:0]);
         cyc(2);
         chk_bit(rate, i[1]);
         chk_bit(fdx, i[0]);
         chk_bit(neg_en, 1'b0);
         mrd(pbmc_pkg::REG_CTRL, exp_ctrl[15:0]);
         mrd(pbmc_pkg::REG_DETAIL, {i[1], i[0], 14'h0000});
      end
      s_neg = 1'b1;
      cyc(2);
      chk_bit(neg_en, 1'b1);
      hs = 1'b1;
      paddr = 5'h00;
      mwr(pbmc_pkg::REG_CTRL, 16'h8000);
      cyc(2);
      chk_bit(busy, 1'b1);
      mwr(pbmc_pkg::REG_CTRL, 16'h0100);
      mrd(pbmc_pkg::REG_CTRL, 16'hB400);
      n = 0;
      while (busy !== 1'b0 && n < 300) begin
         @(negedge clk);
         n++;
      end
      chk_bit(busy, 1'b0);
      if (busy !== 1'b0) begin
         complete_run();
      end
      cyc(2);
      mrd(pbmc_pkg::REG_CTRL, 16'h3400);
      chk_bit(mac_oe, 1'b0);
      complete_run();
   end
endmodule
`default_nettype wire
